// ==== shared/pcx_consts.svh ====
// Constants for the 32-pin port crossbar
`ifndef PCX_CONSTS_SVH
`define PCX_CONSTS_SVH

// Pin count and pin indexes (port 0 at 0..7, port 1 at 8..14)
`define PCX_NUM_PINS      15
`define PCX_NUM_OWNERS    7
`define PCX_PIN_XTAL_A    4'h0
`define PCX_PIN_XTAL_B    4'h1
`define PCX_PIN_PWM0      4'h2
`define PCX_PIN_PWM1      4'h3
`define PCX_PIN_AND_LO    4'h3
`define PCX_PIN_AND_HI    4'h4
`define PCX_PIN_SCL       4'h4
`define PCX_PIN_SDA       4'h5
`define PCX_PIN_SSCK      4'h5
`define PCX_PIN_SMOSI     4'h7
`define PCX_PIN_SDO       4'h8
`define PCX_PIN_SCS       4'h9
`define PCX_PIN_DBG_TCK   4'h7
`define PCX_PIN_DBG_TMS   4'h8
`define PCX_PIN_DBG_TDI   4'h9
`define PCX_PIN_DBG_TDO   4'hA
`define PCX_PIN_DBG_TO    4'hB
`define PCX_PIN_MSCK      4'hC
`define PCX_PIN_MMOSI     4'hD
`define PCX_PIN_MMISO     4'hE
`define PCX_DUAL_LO       4'h4
`define PCX_NUM_DUAL      5
`define PCX_NUM_ANA       11

// Low-frequency clock selection codes
`define PCX_LFSEL_XTAL    3'h0
`define PCX_LFSEL_LOWAMP  3'h3
`define PCX_LFSEL_DIGITAL 3'h4

// Reset values
`define PCX_RST_OE        15'h0000
`define PCX_RST_OUT       15'h0000
`define PCX_RST_ALT       5'h1F

`endif

// ==== shared/pcx_pkg.sv ====
// Types for the 32-pin port crossbar
`default_nettype none
package pcx_pkg;
    // Pin owners, highest priority first
    typedef enum logic [2:0] {
        PCX_OWN_XTAL,
        PCX_OWN_SPIM,
        PCX_OWN_SSPI,
        PCX_OWN_PWM,
        PCX_OWN_ANA,
        PCX_OWN_DBG,
        PCX_OWN_TWI,
        PCX_OWN_GPIO
    } pcx_owner_type;
endpackage : pcx_pkg
`default_nettype wire

// ==== design/pcx_crossbar.sv ====
// Port crossbar for the 32-pin package: pin ownership, output merge, input fan-out
`include "pcx_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pcx_crossbar #(
    parameter int NP = `PCX_NUM_PINS
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [NP-1:0] pad_in_i,
    output logic      [NP-1:0] pad_out_o,
    output logic      [NP-1:0] pad_oe_o,
    output logic      [NP-1:0] pad_value_o,
    output logic      [NP-1:0] port_pin_input_o,
    input  wire logic [NP-1:0] port_pin_output_i,
    input  wire logic [NP-1:0] port_direction_i,
    output logic      [4:0]    alt_input_o,
    input  wire logic          uart_txd_i,
    input  wire logic [2:0]    low_freq_clock_select_i,
    output logic               low_freq_clock_o,
    output logic               xtal_connect_o,
    input  wire logic          spim_en_i,
    input  wire logic          spim_mosi_i,
    input  wire logic          spim_sck_i,
    input  wire logic          sspi_en_i,
    input  wire logic          slave_spi_data_out_i,
    input  wire logic          program_mode_pin_i,
    input  wire logic          flash_spi_data_out_i,
    output logic               flash_active_o,
    input  wire logic [1:0]    pwm_en_i,
    input  wire logic [1:0]    pwm_out_i,
    input  wire logic [10:0]   ana_en_i,
    input  wire logic          dbg_en_i,
    input  wire logic          dbg_tdo_i,
    input  wire logic          dbg_to_i,
    input  wire logic          twi_en_i,
    input  wire logic          twi_scl_low_i,
    input  wire logic          twi_sda_low_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [NP-1:0] meta_r;
    logic [NP-1:0] sync_r;
    logic          pmode_meta_r;
    logic          pmode_r;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_r       <= '0;
            sync_r       <= '0;
            pmode_meta_r <= 1'b0;
            pmode_r      <= 1'b0;
        end
        else
        begin
            meta_r       <= pad_in_i;
            sync_r       <= meta_r;
            pmode_meta_r <= program_mode_pin_i;
            pmode_r      <= pmode_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Claims, drive values and enables per owner and pin
    logic [`PCX_NUM_OWNERS-1:0] claim [NP];
    logic [`PCX_NUM_OWNERS-1:0] dval  [NP];
    logic [`PCX_NUM_OWNERS-1:0] doe   [NP];
    logic                       sspi_on;
    logic                       scs_active;

    // Chip select on P1.1 is active low
    assign scs_active = ~sync_r[`PCX_PIN_SCS];
    // Flash SPI gated by program mode
    assign sspi_on    = sspi_en_i | pmode_r;

    // Owner request table
    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            claim[p] = '0;
            dval[p]  = '0;
            doe[p]   = '0;
        end
        if (low_freq_clock_select_i == `PCX_LFSEL_XTAL)
        begin
            claim[`PCX_PIN_XTAL_A][pcx_pkg::PCX_OWN_XTAL] = 1'b1;
            claim[`PCX_PIN_XTAL_B][pcx_pkg::PCX_OWN_XTAL] = 1'b1;
        end
        // Low-amplitude or digital clock input on P0.1
        if (low_freq_clock_select_i == `PCX_LFSEL_LOWAMP || low_freq_clock_select_i == `PCX_LFSEL_DIGITAL)
        begin
            claim[`PCX_PIN_XTAL_B][pcx_pkg::PCX_OWN_XTAL] = 1'b1;
        end
        // SPI master pins
        claim[`PCX_PIN_MMISO][pcx_pkg::PCX_OWN_SPIM] = spim_en_i;
        claim[`PCX_PIN_MMOSI][pcx_pkg::PCX_OWN_SPIM] = spim_en_i;
        claim[`PCX_PIN_MSCK][pcx_pkg::PCX_OWN_SPIM]  = spim_en_i;
        dval[`PCX_PIN_MMOSI][pcx_pkg::PCX_OWN_SPIM]  = spim_mosi_i;
        dval[`PCX_PIN_MSCK][pcx_pkg::PCX_OWN_SPIM]   = spim_sck_i;
        doe[`PCX_PIN_MMOSI][pcx_pkg::PCX_OWN_SPIM]   = 1'b1;
        doe[`PCX_PIN_MSCK][pcx_pkg::PCX_OWN_SPIM]    = 1'b1;
        // Slave or flash SPI pins
        claim[`PCX_PIN_SCS][pcx_pkg::PCX_OWN_SSPI]   = sspi_on;
        claim[`PCX_PIN_SDO][pcx_pkg::PCX_OWN_SSPI]   = sspi_on;
        claim[`PCX_PIN_SMOSI][pcx_pkg::PCX_OWN_SSPI] = sspi_on;
        claim[`PCX_PIN_SSCK][pcx_pkg::PCX_OWN_SSPI]  = sspi_on;
        dval[`PCX_PIN_SDO][pcx_pkg::PCX_OWN_SSPI]    = pmode_r ? flash_spi_data_out_i : slave_spi_data_out_i;
        // Data out driver only under chip select
        doe[`PCX_PIN_SDO][pcx_pkg::PCX_OWN_SSPI]     = scs_active;
        // Pulse width outputs
        claim[`PCX_PIN_PWM0][pcx_pkg::PCX_OWN_PWM] = pwm_en_i[0];
        claim[`PCX_PIN_PWM1][pcx_pkg::PCX_OWN_PWM] = pwm_en_i[1];
        dval[`PCX_PIN_PWM0][pcx_pkg::PCX_OWN_PWM]  = pwm_out_i[0];
        dval[`PCX_PIN_PWM1][pcx_pkg::PCX_OWN_PWM]  = pwm_out_i[1];
        doe[`PCX_PIN_PWM0][pcx_pkg::PCX_OWN_PWM]   = 1'b1;
        doe[`PCX_PIN_PWM1][pcx_pkg::PCX_OWN_PWM]   = 1'b1;
        // Analog channels sit on pins 0..10, drivers off
        for (int a = 0; a < `PCX_NUM_ANA; a++)
        begin
            claim[a][pcx_pkg::PCX_OWN_ANA] = ana_en_i[a];
        end
        // Hardware debug pins
        claim[`PCX_PIN_DBG_TCK][pcx_pkg::PCX_OWN_DBG] = dbg_en_i;
        claim[`PCX_PIN_DBG_TMS][pcx_pkg::PCX_OWN_DBG] = dbg_en_i;
        claim[`PCX_PIN_DBG_TDI][pcx_pkg::PCX_OWN_DBG] = dbg_en_i;
        claim[`PCX_PIN_DBG_TDO][pcx_pkg::PCX_OWN_DBG] = dbg_en_i;
        claim[`PCX_PIN_DBG_TO][pcx_pkg::PCX_OWN_DBG]  = dbg_en_i;
        dval[`PCX_PIN_DBG_TDO][pcx_pkg::PCX_OWN_DBG]  = dbg_tdo_i;
        dval[`PCX_PIN_DBG_TO][pcx_pkg::PCX_OWN_DBG]   = dbg_to_i;
        doe[`PCX_PIN_DBG_TDO][pcx_pkg::PCX_OWN_DBG]   = 1'b1;
        doe[`PCX_PIN_DBG_TO][pcx_pkg::PCX_OWN_DBG]    = 1'b1;
        // Two-wire open drain: drive low only
        claim[`PCX_PIN_SCL][pcx_pkg::PCX_OWN_TWI] = twi_en_i;
        claim[`PCX_PIN_SDA][pcx_pkg::PCX_OWN_TWI] = twi_en_i;
        doe[`PCX_PIN_SCL][pcx_pkg::PCX_OWN_TWI]   = twi_scl_low_i;
        doe[`PCX_PIN_SDA][pcx_pkg::PCX_OWN_TWI]   = twi_sda_low_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration and output registers
    logic [NP-1:0] out_r;
    logic [NP-1:0] out_nxt;
    logic [NP-1:0] oe_r;
    logic [NP-1:0] oe_nxt;
    logic [NP-1:0] gin_r;
    logic [NP-1:0] gin_nxt;
    logic [4:0]    alt_r;
    logic [4:0]    alt_nxt;
    logic          lfc_r;
    logic          lfc_nxt;
    logic          xtal_r;
    logic          xtal_nxt;

    // Next pin state from the highest claiming owner
    always_comb
    begin
        logic granted;
        granted = 1'b0;
        for (int p = 0; p < NP; p++)
        begin
            granted    = 1'b0;
            out_nxt[p] = port_pin_output_i[p];
            oe_nxt[p]  = port_direction_i[p];
            gin_nxt[p] = sync_r[p];
            // Idle-high transmit passes port value unchanged
            if (p >= `PCX_PIN_AND_LO && p <= `PCX_PIN_AND_HI)
            begin
                out_nxt[p] = port_pin_output_i[p] & uart_txd_i;
            end
            for (int k = 0; k < `PCX_NUM_OWNERS; k++)
            begin
                if (!granted && claim[p][k])
                begin
                    granted    = 1'b1;
                    out_nxt[p] = dval[p][k];
                    oe_nxt[p]  = doe[p][k];
                end
            end
            // Unclaimed pin stays with port logic
            // Merged value drives only when direction is output
            if (!granted)
            begin
                oe_nxt[p] = port_direction_i[p];
            end
            // Port input reads zero while the pin is an output
            if (port_direction_i[p])
            begin
                gin_nxt[p] = 1'b0;
            end
        end
        // Dual block inputs on P0.4..P1.0; idle high otherwise
        for (int d = 0; d < `PCX_NUM_DUAL; d++)
        begin
            alt_nxt[d] = port_direction_i[d + 4] ? 1'b1 : sync_r[d + 4];
        end
        // Clock from P0.1 in low-amplitude or digital mode
        lfc_nxt  = (low_freq_clock_select_i == `PCX_LFSEL_LOWAMP ||
                    low_freq_clock_select_i == `PCX_LFSEL_DIGITAL) ? sync_r[`PCX_PIN_XTAL_B] : 1'b0;
        xtal_nxt = (low_freq_clock_select_i == `PCX_LFSEL_XTAL);
    end

    // Reset leaves every pin an input
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_r  <= `PCX_RST_OUT;
            oe_r   <= `PCX_RST_OE;
            gin_r  <= '0;
            alt_r  <= `PCX_RST_ALT;
            lfc_r  <= 1'b0;
            xtal_r <= 1'b0;
        end
        else
        begin
            out_r  <= out_nxt;
            oe_r   <= oe_nxt;
            gin_r  <= gin_nxt;
            alt_r  <= alt_nxt;
            lfc_r  <= lfc_nxt;
            xtal_r <= xtal_nxt;
        end
    end

    // Output wiring
    assign pad_out_o        = out_r;
    assign pad_oe_o         = oe_r;
    assign pad_value_o      = sync_r;
    assign port_pin_input_o = gin_r;
    assign alt_input_o      = alt_r;
    assign low_freq_clock_o = lfc_r;
    assign xtal_connect_o   = xtal_r;
    assign flash_active_o   = pmode_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_and_merge_out: assert property (@(posedge clk_i) disable iff (rst_i)
        !ana_en_i[3] && !pwm_en_i[1] |=> pad_out_o[3] == ($past(port_pin_output_i[3]) & $past(uart_txd_i)))
        else $error("P0.3 merge wrong");
    a_merge_dir_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !twi_en_i && !ana_en_i[4] && !port_direction_i[4] |=> !pad_oe_o[4])
        else $error("P0.4 driven while input");
    a_idle_tx_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        uart_txd_i && !twi_en_i && !ana_en_i[4] |=> pad_out_o[4] == $past(port_pin_output_i[4]))
        else $error("idle transmit disturbs output");
    a_dual_input: assert property (@(posedge clk_i) disable iff (rst_i)
        !port_direction_i[7] |=> alt_input_o[3] == $past(sync_r[7]) && port_pin_input_o[7] == $past(sync_r[7]))
        else $error("dual input not fed");
    a_sdo_cs_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        sspi_on && !spim_en_i && sync_r[9] |=> !pad_oe_o[8])
        else $error("slave data out driven without select");
    a_flash_pmode: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pmode_r) |-> $past(program_mode_pin_i, 2))
        else $error("flash active without program mode");
    a_xtal_pins_off: assert property (@(posedge clk_i) disable iff (rst_i)
        low_freq_clock_select_i == 3'h0 |=> !pad_oe_o[0] && !pad_oe_o[1] && xtal_connect_o)
        else $error("crystal pins driven");
    a_lfclk_source: assert property (@(posedge clk_i) disable iff (rst_i)
        low_freq_clock_select_i == 3'h3 |=> low_freq_clock_o == $past(sync_r[1]))
        else $error("low-amplitude clock not from P0.1");
    a_lfclk_digital: assert property (@(posedge clk_i) disable iff (rst_i)
        low_freq_clock_select_i == 3'h4 |=> low_freq_clock_o == $past(sync_r[1]) && !pad_oe_o[1])
        else $error("digital clock not taken");
    a_gpio_default: assert property (@(posedge clk_i) disable iff (rst_i)
        !pwm_en_i[0] && !ana_en_i[2] |=> pad_oe_o[2] == $past(port_direction_i[2])
                                        && pad_out_o[2] == $past(port_pin_output_i[2]))
        else $error("idle pin not on port logic");
    a_reset_inputs: assert property (@(posedge clk_i)
        rst_i |-> pad_oe_o == 15'h0000)
        else $error("pin driven in reset");
    a_priority_spim: assert property (@(posedge clk_i) disable iff (rst_i)
        spim_en_i |=> pad_oe_o[13] && pad_out_o[13] == $past(spim_mosi_i))
        else $error("SPI master lost P1.5");
    a_priority_order: assert property (@(posedge clk_i) disable iff (rst_i)
        pwm_en_i[0] && ana_en_i[2] |=> pad_oe_o[2] && pad_out_o[2] == $past(pwm_out_i[0]))
        else $error("pulse width below analog");

endmodule : pcx_crossbar

`default_nettype wire

// ==== tb/pcx_pin_model.sv ====
// Pad world and serial transmitter model beside the crossbar
`timescale 1ns/1ps
`default_nettype none
module pcx_pin_model (
    input  wire logic [14:0] pad_out_i,
    input  wire logic [14:0] pad_oe_i,
    input  wire logic [14:0] ext_level_i,
    input  wire logic        tx_busy_i,
    input  wire logic        tx_bit_i,
    output logic      [14:0] pad_level_o,
    output logic             uart_txd_o
);
    // Pad level: own driver wins, else the outside level
    assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
    assign uart_txd_o = tx_busy_i ? tx_bit_i : 1'b1;
endmodule : pcx_pin_model
`default_nettype wire

// ==== tb/port_crossbar_32pin_bench.sv ====
// Self-checking bench for the 32-pin port crossbar
`timescale 1ns/1ps
`default_nettype none
module port_crossbar_32pin_bench;
    logic        clk_i, rst_i, uart_txd_i, tx_busy, tx_bit;
    logic [14:0] pad_out_o, pad_oe_o, pad_value_o, port_pin_input_o, pad_in_i;
    logic [14:0] port_pin_output_i, port_direction_i, ext_lvl, e;
    logic [4:0]  alt_input_o;
    logic [2:0]  low_freq_clock_select_i;
    logic        low_freq_clock_o, xtal_connect_o, flash_active_o;
    logic        spim_en_i, spim_mosi_i, spim_sck_i, sspi_en_i, slave_spi_data_out_i;
    logic        program_mode_pin_i, flash_spi_data_out_i, dbg_en_i, dbg_tdo_i, dbg_to_i;
    logic        twi_en_i, twi_scl_low_i, twi_sda_low_i;
    logic [1:0]  pwm_en_i, pwm_out_i;
    logic [10:0] ana_en_i;
    int          n_fail, cmp_count;

    ////////////////////////////////////////////////////////////////////////
    // Design and pad world
    pcx_crossbar uut (
        .clk_i(clk_i), .rst_i(rst_i), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
        .pad_value_o(pad_value_o), .port_pin_input_o(port_pin_input_o), .port_pin_output_i(port_pin_output_i),
        .port_direction_i(port_direction_i), .alt_input_o(alt_input_o), .uart_txd_i(uart_txd_i),
        .low_freq_clock_select_i(low_freq_clock_select_i), .low_freq_clock_o(low_freq_clock_o),
        .xtal_connect_o(xtal_connect_o), .spim_en_i(spim_en_i), .spim_mosi_i(spim_mosi_i),
        .spim_sck_i(spim_sck_i), .sspi_en_i(sspi_en_i), .slave_spi_data_out_i(slave_spi_data_out_i),
        .program_mode_pin_i(program_mode_pin_i), .flash_spi_data_out_i(flash_spi_data_out_i),
        .flash_active_o(flash_active_o), .pwm_en_i(pwm_en_i), .pwm_out_i(pwm_out_i), .ana_en_i(ana_en_i),
        .dbg_en_i(dbg_en_i), .dbg_tdo_i(dbg_tdo_i), .dbg_to_i(dbg_to_i), .twi_en_i(twi_en_i),
        .twi_scl_low_i(twi_scl_low_i), .twi_sda_low_i(twi_sda_low_i)
    );
    pcx_pin_model pins (
        .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .ext_level_i(ext_lvl), .tx_busy_i(tx_busy),
        .tx_bit_i(tx_bit), .pad_level_o(pad_in_i), .uart_txd_o(uart_txd_i)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Port output after the transmit merge on pins 3 and 4
    function automatic logic [14:0] gout(input logic [14:0] d, input logic t);
        gout = d;
        gout[4:3] = d[4:3] & {2{t}};
    endfunction : gout
    // Second block inputs on top, port inputs below
    function automatic logic [19:0] fan(input logic [14:0] lvl, input logic [14:0] dir);
        fan = {(lvl[8:4] & ~dir[8:4]) | dir[8:4], lvl & ~dir};
    endfunction : fan
    task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step
    // All blocks off, data lines random
    task automatic idle();
        {spim_en_i, sspi_en_i, program_mode_pin_i, dbg_en_i, twi_en_i, tx_busy} = 6'h00;
        {pwm_en_i, ana_en_i, low_freq_clock_select_i} = {13'h0000, 3'h7};
        {spim_mosi_i, spim_sck_i, slave_spi_data_out_i, flash_spi_data_out_i, tx_bit} = 5'($urandom);
        {dbg_tdo_i, dbg_to_i, twi_scl_low_i, twi_sda_low_i, pwm_out_i} = 6'($urandom);
        {port_pin_output_i, port_direction_i, ext_lvl} = 45'({$urandom, $urandom});
    endtask : idle

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial
    begin
        #200us;
        n_fail++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        void'($urandom(32'h3E0B));
        idle();
        rst_i = 1'b1;
        step(8);
        check("oe_rst", pad_oe_o, 20'h00000);
        check("in_rst", {alt_input_o, port_pin_input_o}, 20'hF8000);
        rst_i = 1'b0;
        // Random port traffic with the transmitter busy or idle
        repeat (30)
        begin
            idle();
            {tx_busy, tx_bit} = 2'($urandom);
            step(1);
            check("gpio_oe", pad_oe_o, port_direction_i);
            check("gpio_out", pad_out_o & port_direction_i, gout(port_pin_output_i, uart_txd_i) & port_direction_i);
            // Pad settles at the first edge, then two sync edges and the output register
            step(3);
            check("gpio_in", {alt_input_o, port_pin_input_o}, fan(ext_lvl, port_direction_i));
            e = (ext_lvl & ~port_direction_i) | (gout(port_pin_output_i, uart_txd_i) & port_direction_i);
            check("pad_val", pad_value_o, e);
        end
        // Competing blocks, GPIO asks for output everywhere
        idle();
        port_direction_i = 15'h7FFF;
        {spim_en_i, dbg_en_i, twi_en_i, twi_scl_low_i, twi_sda_low_i} = 5'h1E;
        {pwm_en_i, ana_en_i, low_freq_clock_select_i} = {2'h1, 11'h404, 3'h0};
        step(1);
        e = gout(port_pin_output_i, uart_txd_i);
        {e[13:11], e[4], e[2]} = {spim_mosi_i, spim_sck_i, dbg_to_i, 1'b0, pwm_out_i[0]};
        check("prio_oe", pad_oe_o, 15'h385C);
        check("prio_out", pad_out_o & 15'h385C, e & 15'h385C);
        check("xtal", xtal_connect_o, 1'b1);
        ana_en_i = 11'h000;
        step(1);
        check("dbg_tdo", {pad_oe_o[10], pad_out_o[10]}, {1'b1, dbg_tdo_i});
        // Slave data driver follows chip select, then program mode
        idle();
        port_direction_i = 15'h0000;
        sspi_en_i = 1'b1;
        ext_lvl[9] = 1'b1;
        step(4);
        check("sdo_off", pad_oe_o[8], 1'b0);
        ext_lvl[9] = 1'b0;
        step(4);
        check("sdo_on", {pad_oe_o[8], pad_out_o[8]}, {1'b1, slave_spi_data_out_i});
        sspi_en_i = 1'b0;
        step(4);
        check("flash_off", {flash_active_o, pad_oe_o[8]}, 2'b00);
        program_mode_pin_i = 1'b1;
        step(4);
        check("flash_on", {flash_active_o, pad_oe_o[8], pad_out_o[8]}, {2'b11, flash_spi_data_out_i});
        // Every clock selection code, pin 1 toggled twice
        for (int s = 0; s < 8; s++)
        begin
            idle();
            port_direction_i = 15'h7FFF;
            low_freq_clock_select_i = 3'(s);
            repeat (2)
            begin
                ext_lvl[1] = ~ext_lvl[1];
                step(4);
                check("xtal_sel", xtal_connect_o, s == 0);
                check("xtal_oe", pad_oe_o[1:0], s == 0 ? 2'b00 : (s == 3 || s == 4) ? 2'b01 : 2'b11);
                check("lf_clk", low_freq_clock_o, (s == 3 || s == 4) ? ext_lvl[1] : 1'b0);
                check("lf_dig", {xtal_connect_o, low_freq_clock_o} & {2{s == 4}}, {1'b0, ext_lvl[1]} & {2{s == 4}});
            end
        end
        stop_test();
    end
endmodule : port_crossbar_32pin_bench
`default_nettype wire
